// ==== hw/hcs_params.svh ====
`ifndef HCS_PARAMS_SVH
`define HCS_PARAMS_SVH
// pointer register layout
`define HCS_PTR_W        24
`define HCS_IDX_MSB      3
`define HCS_SE_BIT       4
`define HCS_UF_BIT       5
`define HCS_PTR_RESET    24'h000000
// pointer values in non-extended mode
`define HCS_FULL_IDX     4'hF
`define HCS_OVF_SINGLE   6'h10
`define HCS_OVF_DOUBLE   6'h11
`define HCS_UNF_SINGLE   6'h3F
`define HCS_UNF_DOUBLE   6'h3E
// fill counter
`define HCS_CNT_W        5
`define HCS_CNT_RESET    5'h00
`define HCS_CNT_HI_TRIG  5'h0E
`define HCS_CNT_LO_TRIG  5'h02
`define HCS_CNT_SPILL_AT 5'h0F
`define HCS_CNT_REFILL_AT 5'h00
// one spill or refill moves this many entries
`define HCS_XFER_ENTRIES 5'h01
// stack error exception priority
`define HCS_ERR_LEVEL    2'h3
`endif

// ==== hw/hcs_pkg.sv ====
package hcs_pkg;
  // implicit stack operation requested by the sequencer
  typedef enum logic [2:0] {
    HCS_OP_NONE,
    HCS_OP_CALL,
    HCS_OP_RTS,
    HCS_OP_RTI,
    HCS_OP_LOOP,
    HCS_OP_LOOP_END
  } hcs_op_t;
  // explicit register moves
  typedef enum logic [2:0] {
    HCS_REG_HIGH,
    HCS_REG_LOW,
    HCS_REG_PTR,
    HCS_REG_CNT,
    HCS_REG_SIZE
  } hcs_reg_t;
endpackage

// ==== hw/hcs_stack.sv ====
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - sixteen 48-bit entries, two 24-bit halves
// - call pushes return address and status
// - subroutine return pulls address, status kept
// - interrupt return pulls address and status
// - loop start pushes loop state, then address
// - high-half moves change pointer, low-half not
// - non-extended nesting limited to fifteen entries
// - stack error rise raises level-3 exception
// - select bit picks X or Y memory
// - after push, spill oldest entry when full
// - after pull, refill from memory when empty
// - reset empties; push pre-increments, pull post-decrements
// - pointer fields; full counter when extended
// - underflow flag sticky until software write
// - push at fifteen gives overflow pointer values
// - pull at zero gives underflow pointer values
// - error sticky until software clears it
// - five-bit fill counter, cleared by reset
// - counter write outside 2..14 triggers a transfer check
// - push at size limit flags extended overflow
// - extension pointer addresses spill memory
`include "hcs_params.svh"
module hcs_stack
  import hcs_pkg::*;
#(
  parameter int DEPTH = 16,  // on-chip entries
  parameter int HW    = 24   // half-entry width
)(
  input  wire logic          mclk,          // core clock
  input  wire logic          rst_b,         // async reset, low active
  input  wire hcs_op_t       op,            // implicit operation, one cycle
  input  wire logic [HW-1:0] program_counter_value, // pc to stack
  input  wire logic [HW-1:0] status_word,   // status to stack
  input  wire logic [HW-1:0] loop_count_value, // loop count to stack
  input  wire logic [HW-1:0] loop_end_address, // loop end to stack
  output logic [HW-1:0]      pc_out,        // pulled pc
  output logic [HW-1:0]      sr_out,        // pulled status
  output logic               pc_load,       // load pc_out, pulse
  output logic               sr_load,       // load sr_out, pulse
  output logic [HW-1:0]      lc_out,        // pulled loop count
  output logic [HW-1:0]      la_out,        // pulled loop end
  output logic               loop_load,     // loop regs valid, pulse
  input  wire logic          mv_wr,         // explicit write, pulse
  input  wire logic          mv_rd,         // explicit read, pulse
  input  wire hcs_reg_t      mv_sel,        // register selected
  input  wire logic [HW-1:0] mv_wdata,      // write data
  output logic [HW-1:0]      mv_rdata,      // read data, registered
  input  wire logic          stack_extend_enable, // mode word enable bit
  input  wire logic          extension_space_select, // 0 X, 1 Y
  input  wire logic [HW-1:0] extension_memory_pointer, // spill base
  output logic [HW-1:0]      ep_out,        // updated extension pointer
  output logic               ep_load,       // ep_out valid, pulse
  output logic               mem_req,       // memory access request
  output logic               mem_we,        // 1 spill, 0 refill
  output logic               mem_space_y,   // memory space select
  output logic [HW-1:0]      mem_addr,      // word address
  output logic [HW-1:0]      mem_wdata,     // word written
  input  wire logic [HW-1:0] mem_rdata,     // word read
  input  wire logic          mem_ack,       // access done (after waits)
  output logic               stall,         // hold instruction flow
  output logic               err_irq,       // stack error exception, pulse
  output logic [1:0]         err_level,     // exception priority
  output logic               ext_overflow   // extended overflow flag
);
  // ==========================================================
  // elaboration check: index slices and field layout assume this shape
  if (DEPTH != 16 || HW != 24)
  begin : g_shape_chk
    $error("hcs_stack serves only 16 x 24-bit halves");
  end

  // ==========================================================
  // storage and state
  logic [HW-1:0]  hi_mem [DEPTH];         // high halves
  logic [HW-1:0]  lo_mem [DEPTH];         // low halves
  logic [`HCS_PTR_W-1:0] sp_q;            // pointer register
  logic [`HCS_CNT_W-1:0] sc_q;            // fill counter
  logic [HW-1:0]  sz_q;                   // size limit, no reset
  logic           ovf_q;                  // extended overflow latch
  logic [HW-1:0]  ep_q;                   // working extension pointer
  typedef enum logic [2:0] {X_IDLE, X_SP_HI, X_SP_LO, X_RF_LO, X_RF_HI} hcs_xs_t;
  hcs_xs_t        xs_q;                   // transfer sequencer
  logic           loop2_q;                // loop second half pending
  wire logic [3:0] idx = sp_q[`HCS_IDX_MSB:0];
  wire logic [3:0] idx_p1 = idx + 4'h1;
  wire logic [3:0] idx_m1 = idx - 4'h1;
  // oldest live entry sits sc-1 below top
  wire logic [3:0] old_idx = idx - sc_q[3:0] + 4'h1;
  // ==========================================================
  // decode of pushes and pulls
  wire logic mv_hi_wr = mv_wr && mv_sel == HCS_REG_HIGH;
  wire logic mv_hi_rd = mv_rd && mv_sel == HCS_REG_HIGH;
  wire logic mv_lo_wr = mv_wr && mv_sel == HCS_REG_LOW;
  wire logic busy     = xs_q != X_IDLE;
  // loop start is a double push spread over two cycles
  wire logic push = !busy && (op == HCS_OP_CALL || op == HCS_OP_LOOP
                    || loop2_q || mv_hi_wr);
  wire logic pull = !busy && (op == HCS_OP_RTS || op == HCS_OP_RTI
                    || op == HCS_OP_LOOP_END || mv_hi_rd);
  wire logic ext  = stack_extend_enable;
  // non-extended error conditions
  wire logic ovf_ne = !ext && push && sp_q[5:0] >= {2'b00, `HCS_FULL_IDX};
  wire logic unf_ne = !ext && pull && sp_q[5:0] == 6'h00;
  wire logic se_ne  = !ext && sp_q[`HCS_SE_BIT];
  // ==========================================================
  // stack pointer: pre-increment push, post-decrement pull
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      sp_q <= `HCS_PTR_RESET;
    else if (mv_wr && mv_sel == HCS_REG_PTR)
      sp_q <= mv_wdata;
    else if (ext)
    begin
      // extended: whole register is one counter
      if (push)
        sp_q <= sp_q + 24'h000001;
      else if (pull)
        sp_q <= sp_q - 24'h000001;
    end
    else if (unf_ne)
      sp_q <= {18'h0, `HCS_UNF_SINGLE};
    else if (pull && sp_q[`HCS_UF_BIT] && sp_q[5:0] == `HCS_UNF_SINGLE)
      sp_q <= {18'h0, `HCS_UNF_DOUBLE};
    else if (ovf_ne && sp_q[5:0] == {2'b00, `HCS_FULL_IDX})
      sp_q <= {18'h0, `HCS_OVF_SINGLE};
    else if (ovf_ne && sp_q[5:0] == `HCS_OVF_SINGLE)
      sp_q <= {18'h0, `HCS_OVF_DOUBLE};
    else if (push && !se_ne)
      sp_q <= sp_q + 24'h000001;
    else if (pull && !se_ne)
      sp_q <= sp_q - 24'h000001;
  end

  // ==========================================================
  // entry storage; spill and refill share the ports
  always_ff @(posedge mclk)
  begin
    if (op == HCS_OP_CALL && push)
    begin
      hi_mem[idx_p1] <= program_counter_value;
      lo_mem[idx_p1] <= status_word;
    end
    else if (op == HCS_OP_LOOP && push)
    begin
      hi_mem[idx_p1] <= loop_end_address;
      lo_mem[idx_p1] <= loop_count_value;
    end
    else if (loop2_q && push)
    begin
      hi_mem[idx_p1] <= program_counter_value;
      lo_mem[idx_p1] <= status_word;
    end
    else if (mv_hi_wr && push)
      hi_mem[idx_p1] <= mv_wdata;
    else if (mv_lo_wr)
      lo_mem[idx] <= mv_wdata;
    else if (xs_q == X_RF_LO && mem_ack)
      lo_mem[old_idx - 4'h1] <= mem_rdata;
    else if (xs_q == X_RF_HI && mem_ack)
      hi_mem[old_idx - 4'h1] <= mem_rdata;
  end

  // loop second push follows first by one cycle
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      loop2_q <= 1'b0;
    else if (op == HCS_OP_LOOP && push && !ovf_ne)
      loop2_q <= 1'b1;
    else if (push || ovf_ne)
      loop2_q <= 1'b0;
  end

  // ==========================================================
  // pulled values to the sequencer
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pc_out    <= '0;
      sr_out    <= '0;
      lc_out    <= '0;
      la_out    <= '0;
      pc_load   <= 1'b0;
      sr_load   <= 1'b0;
      loop_load <= 1'b0;
    end
    else
    begin
      pc_load   <= pull && (op == HCS_OP_RTS || op == HCS_OP_RTI);
      sr_load   <= pull && op == HCS_OP_RTI;
      loop_load <= pull && op == HCS_OP_LOOP_END;
      if (pull)
      begin
        pc_out <= hi_mem[idx];
        sr_out <= lo_mem[idx];
        la_out <= hi_mem[idx];
        lc_out <= lo_mem[idx];
      end
    end
  end

  // ==========================================================
  // explicit reads, registered
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      mv_rdata <= '0;
    else if (mv_rd)
    begin
      case (mv_sel)
        HCS_REG_HIGH: mv_rdata <= hi_mem[idx];
        HCS_REG_LOW:  mv_rdata <= lo_mem[idx];
        HCS_REG_PTR:  mv_rdata <= sp_q;
        HCS_REG_CNT:  mv_rdata <= {19'h0, sc_q};
        HCS_REG_SIZE: mv_rdata <= sz_q;
        default:      mv_rdata <= '0;
      endcase
    end
  end

  // ==========================================================
  // size limit: no reset, software loads it first
  always_ff @(posedge mclk)
  begin
    if (mv_wr && mv_sel == HCS_REG_SIZE)
      sz_q <= mv_wdata;
  end

  // extended overflow latch until next pointer write
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      ovf_q <= 1'b0;
    else if (ext && push && sp_q == sz_q)
      ovf_q <= 1'b1;
    else if (mv_wr && mv_sel == HCS_REG_PTR)
      ovf_q <= 1'b0;
  end

  // ==========================================================
  // fill counter
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      sc_q <= `HCS_CNT_RESET;
    else if (mv_wr && mv_sel == HCS_REG_CNT)
      sc_q <= mv_wdata[`HCS_CNT_W-1:0];
    else if (xs_q == X_SP_LO && mem_ack)
      sc_q <= sc_q - `HCS_XFER_ENTRIES;
    else if (xs_q == X_RF_HI && mem_ack)
      sc_q <= sc_q + `HCS_XFER_ENTRIES;
    else if (push && !ovf_ne && sc_q < `HCS_CNT_SPILL_AT + 5'h01)
      sc_q <= sc_q + 5'h01;
    else if (pull && !unf_ne && sc_q != `HCS_CNT_RESET)
      sc_q <= sc_q - 5'h01;
  end

  // ==========================================================
  // spill and refill sequencer, one 48-bit entry as two words
  // counter write outside 2..14 also kicks the machine
  wire logic sc_wr   = mv_wr && mv_sel == HCS_REG_CNT;
  wire logic kick    = sc_wr && (mv_wdata[`HCS_CNT_W-1:0] > `HCS_CNT_HI_TRIG
                       || mv_wdata[`HCS_CNT_W-1:0] < `HCS_CNT_LO_TRIG);
  wire logic need_sp = sc_q >= `HCS_CNT_SPILL_AT;
  wire logic need_rf = sc_q == `HCS_CNT_REFILL_AT && sp_q != 24'h0;
  logic      chk_q;                                                 // check pending
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      chk_q <= 1'b0;
    else
      chk_q <= ext && (push || pull || kick);
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      xs_q <= X_IDLE;
      ep_q <= '0;
    end
    else
    begin
      case (xs_q)
        X_IDLE:
          if (chk_q && ext && need_sp)
          begin
            xs_q <= X_SP_HI;
            ep_q <= extension_memory_pointer;
          end
          else if (chk_q && ext && need_rf)
          begin
            xs_q <= X_RF_LO;
            ep_q <= extension_memory_pointer - 24'h000001;
          end
        X_SP_HI:
          if (mem_ack)
          begin
            xs_q <= X_SP_LO;
            ep_q <= ep_q + 24'h000001;
          end
        X_SP_LO:
          if (mem_ack)
          begin
            xs_q <= X_IDLE;
            ep_q <= ep_q + 24'h000001;
          end
        X_RF_LO:
          if (mem_ack)
          begin
            xs_q <= X_RF_HI;
            ep_q <= ep_q - 24'h000001;
          end
        X_RF_HI:
          if (mem_ack)
            xs_q <= X_IDLE;
        default:
          xs_q <= X_IDLE;
      endcase
    end
  end

  // memory side; addresses follow the working pointer
  always_comb
  begin
    mem_req   = busy;
    mem_we    = xs_q == X_SP_HI || xs_q == X_SP_LO;
    mem_addr  = ep_q;
    mem_wdata = xs_q == X_SP_HI ? hi_mem[old_idx] : lo_mem[old_idx];
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      ep_load <= 1'b0;
    else
      ep_load <= mem_ack && (xs_q == X_SP_LO || xs_q == X_RF_HI);
  end

  // ==========================================================
  // exception: rising edge of error flag, non-extended only
  logic se_d1_q;                                                    // last flag
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      se_d1_q <= 1'b0;
    else
      se_d1_q <= se_ne;
  end

  always_comb
  begin
    mem_space_y  = extension_space_select;
    stall        = busy || chk_q || loop2_q;
    err_irq      = se_ne && !se_d1_q;
    err_level    = `HCS_ERR_LEVEL;
    ext_overflow = ovf_q;
    ep_out       = ep_q;
  end

endmodule
`default_nettype wire

// ==== tb/hcs_stack_props.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================
// port checker for the call stack
module hcs_stack_props
  import hcs_pkg::*;
(
  input wire logic        mclk,                   // core clock
  input wire logic        rst_b,                  // reset, low active
  input wire hcs_op_t     op,                     // implicit operation
  input wire logic        stall,                  // flow hold
  input wire logic        pc_load,                // pulled address valid
  input wire logic        sr_load,                // pulled status valid
  input wire logic        stack_extend_enable,    // extension on
  input wire logic        extension_space_select, // 0 x, 1 y
  input wire logic        mem_req,                // memory request
  input wire logic        mem_we,                 // spill write
  input wire logic        mem_space_y,            // space driven
  input wire logic [23:0] mem_addr,               // word address
  input wire logic        mem_ack,                // access done
  input wire logic        err_irq,                // error exception
  input wire logic [1:0]  err_level               // exception level
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);
  // one word done, the next word of the same entry follows
  sequence spill_pair_s;
    (mem_req && mem_we && mem_ack) ##1 mem_req;
  endsequence
  sequence refill_pair_s;
    (mem_req && !mem_we && mem_ack) ##1 mem_req;
  endsequence
  rts_pulls_a: assert property (op == HCS_OP_RTS && !stall |=> pc_load && !sr_load)
    else $error("subroutine return loads wrong");
  rti_pulls_a: assert property (op == HCS_OP_RTI && !stall |=> pc_load && sr_load)
    else $error("interrupt return loads wrong");
  loop_two_cycle_a: assert property (op == HCS_OP_LOOP && !stall |=> stall)
    else $error("loop start took one cycle");
  irq_level_a: assert property (err_irq |-> err_level == 2'h3)
    else $error("error level wrong");
  irq_pulse_a: assert property (err_irq |-> !stack_extend_enable ##1 !err_irq)
    else $error("error exception in wrong mode or long");
  space_sel_a: assert property (mem_req |-> mem_space_y == extension_space_select)
    else $error("memory space wrong");
  spill_step_a: assert property (spill_pair_s |-> mem_we && mem_addr == $past(mem_addr) + 24'h000001)
    else $error("spill address step wrong");
  refill_step_a: assert property (refill_pair_s |-> !mem_we && mem_addr == $past(mem_addr) - 24'h000001)
    else $error("refill address step wrong");
  req_hold_a: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we))
    else $error("memory request dropped early");
  req_stall_a: assert property (mem_req |-> stall && stack_extend_enable)
    else $error("transfer without stall");
endmodule
bind hcs_stack hcs_stack_props u_props (
  .mclk(mclk), .rst_b(rst_b), .op(op), .stall(stall), .pc_load(pc_load), .sr_load(sr_load),
  .stack_extend_enable(stack_extend_enable), .extension_space_select(extension_space_select),
  .mem_req(mem_req), .mem_we(mem_we), .mem_space_y(mem_space_y), .mem_addr(mem_addr),
  .mem_ack(mem_ack), .err_irq(err_irq), .err_level(err_level)
);
`default_nettype wire

// ==== tb/hcs_mem_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================
// data memory holding spilled entries
module hcs_mem_model (
  input  wire logic        mclk,        // core clock
  input  wire logic        rst_b,       // reset, low active
  input  wire logic [3:0]  waits,       // wait states per word
  input  wire logic        mem_req,     // request
  input  wire logic        mem_we,      // write
  input  wire logic        mem_space_y, // y space
  input  wire logic [23:0] mem_addr,    // word address
  input  wire logic [23:0] mem_wdata,   // write word
  output logic [23:0]      mem_rdata,   // read word
  output logic             mem_ack      // word done
);
  logic [23:0] xm [0:255]; // x space, low address bits only
  logic [23:0] ym [0:255]; // y space
  logic [3:0]  wait_q;     // waits served so far
  logic [23:0] last_q;     // last word shown
  // known fill so stale reads are visible
  initial
  begin
    for (int i = 0; i < 256; i++)
    begin
      xm[i] = 24'hA50000 | 24'(i);
      ym[i] = 24'h5A0000 | 24'(i);
    end
  end
  assign mem_ack = mem_req && (wait_q == waits);
  // off-access the bus shows the inverse of the last word
  assign mem_rdata = (mem_ack && !mem_we) ?
    (mem_space_y ? ym[mem_addr[7:0]] : xm[mem_addr[7:0]]) : ~last_q;
  // wait counting and storage; plain always since the fill above shares the arrays
  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wait_q <= 4'h0;
      last_q <= 24'h000000;
    end
    else
    begin
      wait_q <= mem_ack ? 4'h0 : (mem_req ? wait_q + 4'h1 : 4'h0);
      if (mem_ack && mem_we && mem_space_y)
        ym[mem_addr[7:0]] <= mem_wdata;
      if (mem_ack && mem_we && !mem_space_y)
        xm[mem_addr[7:0]] <= mem_wdata;
      if (mem_ack)
        last_q <= mem_ack && !mem_we ? mem_rdata : mem_wdata;
    end
  end
endmodule
`default_nettype wire

// ==== tb/hcs_stack_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================
// call stack bench
module hcs_stack_tb_top
  import hcs_pkg::*;
;
  logic        mclk, rst_b, pc_load, sr_load, loop_load, mv_wr, mv_rd, ep_load;
  logic        stack_extend_enable, extension_space_select, mem_req, mem_we, mem_space_y;
  logic        mem_ack, stall, err_irq, ext_overflow, rd_pend, mute;
  hcs_op_t     op;          // implicit operation
  hcs_reg_t    mv_sel;      // moved register
  logic [23:0] program_counter_value, status_word, loop_count_value, loop_end_address;
  logic [23:0] pc_out, sr_out, lc_out, la_out, mv_wdata, mv_rdata, xptr_q, ep_out;
  logic [23:0] mem_addr, mem_wdata, mem_rdata, w;
  logic [1:0]  err_level;   // exception level
  logic [3:0]  waits;       // memory wait states
  int          err_total, n_compared, n_irq, seed;
  logic [23:0] exp_ret[$], exp_stat[$], exp_rd[$], rets[$], stats[$]; // notes
  hcs_stack DUT (.mclk(mclk), .rst_b(rst_b), .op(op), .program_counter_value(program_counter_value),
    .status_word(status_word), .loop_count_value(loop_count_value),
    .loop_end_address(loop_end_address), .pc_out(pc_out), .sr_out(sr_out), .pc_load(pc_load),
    .sr_load(sr_load), .lc_out(lc_out), .la_out(la_out), .loop_load(loop_load), .mv_wr(mv_wr),
    .mv_rd(mv_rd), .mv_sel(mv_sel), .mv_wdata(mv_wdata), .mv_rdata(mv_rdata),
    .stack_extend_enable(stack_extend_enable), .extension_space_select(extension_space_select),
    .extension_memory_pointer(xptr_q), .ep_out(ep_out), .ep_load(ep_load), .mem_req(mem_req),
    .mem_we(mem_we), .mem_space_y(mem_space_y), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack), .stall(stall), .err_irq(err_irq),
    .err_level(err_level), .ext_overflow(ext_overflow));
  hcs_mem_model u_mem (.mclk(mclk), .rst_b(rst_b), .waits(waits), .mem_req(mem_req),
    .mem_we(mem_we), .mem_space_y(mem_space_y), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack));
  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // ==========================
  // compare and closing tasks
  task automatic cmp_w(input logic [23:0] got, input logic [23:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic cmp_n(input int got, input int exp);
    cmp_w(24'(got), 24'(exp));
  endtask
  task automatic take(ref logic [23:0] q[$], input logic [23:0] got);
    if (q.size() == 0)
      cmp_n(1, 0);
    else
      cmp_w(got, q.pop_front());
  endtask
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ==========================
  // drivers, always 2 ns after the edge
  task automatic tick();
    @(posedge mclk);
    #2;
  endtask
  task automatic idle(); // bounded wait for the stall to drop
    for (int k = 0; k < 400 && stall !== 1'b0; k++)
      tick();
  endtask
  task automatic rst();
    rst_b = 1'b0;
    stack_extend_enable = 1'b0;
    repeat (5) tick();
    rst_b = 1'b1;
  endtask
  task automatic push(input hcs_op_t o, input bit rec);
    idle();
    program_counter_value = 24'($random(seed));
    status_word = 24'($random(seed));
    loop_count_value = 24'($random(seed));
    loop_end_address = 24'($random(seed));
    op = o;
    if (rec)
      rets.push_back(program_counter_value);
    if (rec)
      stats.push_back(status_word);
    tick();
    op = HCS_OP_NONE;
    tick();
  endtask
  task automatic pull(input hcs_op_t o);
    idle();
    op = o;
    exp_ret.push_back(rets.pop_back());
    if (o == HCS_OP_RTI)
      exp_stat.push_back(stats.pop_back());
    else
      void'(stats.pop_back());
    tick();
    op = HCS_OP_NONE;
    tick();
  endtask
  task automatic mv(input logic wr, input hcs_reg_t s, input logic [23:0] d);
    idle();
    mv_sel = s;
    {mv_wr, mv_rd, mv_wdata} = {wr, !wr, d};
    tick();
    {mv_wr, mv_rd} = 2'h0;
    tick();
  endtask
  task automatic rd(input hcs_reg_t s, input logic [23:0] e);
    exp_rd.push_back(e);
    mv(1'b0, s, 24'h000000);
  endtask
  // monitor: each result takes the oldest note
  always @(posedge mclk)
  begin
    if (rd_pend === 1'b1)
      take(exp_rd, mv_rdata);
    rd_pend <= mv_rd && !stall;
    if (pc_load === 1'b1 && !mute)
      take(exp_ret, pc_out);
    if (sr_load === 1'b1 && !mute)
      take(exp_stat, sr_out);
    if (loop_load === 1'b1)
      take(exp_ret, la_out);
    if (loop_load === 1'b1)
      take(exp_stat, lc_out);
    if (err_irq === 1'b1)
      n_irq++;
    if (rst_b === 1'b0)
      xptr_q <= 24'h000040; // spill area base after every reset
    else if (ep_load === 1'b1)
      xptr_q <= ep_out;
  end
  initial
  begin
    #500000;
    err_total++;
    $display("unexpected at %0t: run hung", $time);
    end_of_test();
  end
  // ==========================
  // scenarios
  initial
  begin
    seed = 32'h2FBBD60E;
    op = HCS_OP_NONE;
    mv_sel = HCS_REG_PTR;
    waits = 4'h0;
    {mv_wr, mv_rd, mute, extension_space_select, mv_wdata} = 28'h0000000;
    {program_counter_value, status_word, loop_count_value, loop_end_address} = 96'h0;
    rst();
    rd(HCS_REG_PTR, 24'h000000);
    rd(HCS_REG_CNT, 24'h000000);
    for (int i = 0; i < 15; i++)
      push(HCS_OP_CALL, 1'b1);
    rd(HCS_REG_PTR, 24'h00000F);
    cmp_n(n_irq, 0);
    push(HCS_OP_CALL, 1'b0);
    rd(HCS_REG_PTR, 24'h000010);
    cmp_n(n_irq, 1);
    mv(1'b1, HCS_REG_PTR, 24'h00000F);
    for (int i = 0; i < 15; i++)
      pull(i[0] ? HCS_OP_RTI : HCS_OP_RTS);
    rd(HCS_REG_PTR, 24'h000000);
    mute = 1'b1;
    push(HCS_OP_RTS, 1'b0);
    rd(HCS_REG_PTR, 24'h00003F);
    rd(HCS_REG_PTR, 24'h00003F);
    cmp_n(n_irq, 2);
    mute = 1'b0;
    mv(1'b1, HCS_REG_PTR, 24'h000000);
    rd(HCS_REG_PTR, 24'h000000);
    w = 24'($random(seed));
    mv(1'b1, HCS_REG_HIGH, w);
    mv(1'b1, HCS_REG_LOW, ~w);
    rd(HCS_REG_PTR, 24'h000001);
    rd(HCS_REG_LOW, ~w);
    rd(HCS_REG_HIGH, w);
    rd(HCS_REG_PTR, 24'h000000);
    push(HCS_OP_LOOP, 1'b0);
    rd(HCS_REG_PTR, 24'h000002);
    rd(HCS_REG_LOW, status_word);
    rd(HCS_REG_HIGH, program_counter_value);
    exp_ret.push_back(loop_end_address);
    exp_stat.push_back(loop_count_value);
    push(HCS_OP_LOOP_END, 1'b0);
    for (int s = 0; s < 2; s++)
    begin
      rst();
      {waits, extension_space_select} = {4'(s * 3), s[0]};
      mv(1'b1, HCS_REG_SIZE, 24'h0000FF);
      stack_extend_enable = 1'b1;
      for (int i = 0; i < 15; i++)
        push(HCS_OP_CALL, 1'b1);
      idle();
      tick();
      cmp_w(xptr_q, 24'h000042);
      cmp_w(s ? u_mem.ym[8'h40] : u_mem.xm[8'h40], rets[0]);
      cmp_w(s ? u_mem.ym[8'h41] : u_mem.xm[8'h41], stats[0]);
      for (int i = 0; i < 14; i++)
        pull(HCS_OP_RTS);
      idle();
      tick();
      cmp_w(xptr_q, 24'h000040);
      pull(HCS_OP_RTI);
      idle();
    end
    rst();
    mv(1'b1, HCS_REG_SIZE, 24'h000002);
    stack_extend_enable = 1'b1;
    push(HCS_OP_CALL, 1'b0);
    push(HCS_OP_CALL, 1'b0);
    cmp_w({23'h0, ext_overflow}, 24'h000000);
    push(HCS_OP_CALL, 1'b0);
    cmp_w({23'h0, ext_overflow}, 24'h000001);
    mv(1'b1, HCS_REG_CNT, 24'h000000);
    idle();
    tick();
    cmp_w(xptr_q, 24'h00003E);
    rd(HCS_REG_CNT, 24'h000001);
    cmp_n(exp_ret.size() + exp_rd.size(), 0);
    end_of_test();
  end
endmodule
`default_nettype wire
